// ---- core/supply_status_pkg.sv ----
// constants and carriers for the supply status and event mask register
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package supply_status_pkg;
    localparam logic [7:0] STATUS_ADDR = 8'h07;
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam int ATTACHED_BIT = 7;
    localparam int PGOOD_BIT = 6;
    localparam int FAIL_BIT = 5;
    localparam int RSVD_BIT = 4;
    localparam int MASK_ATTACH_BIT = 3;
    localparam int MASK_PGOOD_BIT = 2;
    localparam int MASK_FAIL_BIT = 1;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam longint CLK_HZ = 40_000_000;
    localparam longint RETRY_S = 2;
    localparam int RETRY_CYC = int'(RETRY_S * CLK_HZ);
    localparam longint PULSE_US = 10;
    localparam int PULSE_CYC = int'((PULSE_US * CLK_HZ + 999_999) / 1_000_000);

    // register access from the serial interface engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // analog supply comparators
    typedef struct packed {
        logic present;
        logic in_range;
        logic overvoltage;
    } supply_sense_s;

    typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ATTACHED, ST_FAILED} valid_state_e;
endpackage

// ---- core/supply_status_interrupt_reg.sv ----
// supply status and event mask register with validation sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_status_interrupt_reg #(
    parameter int RETRY_CYCLES = supply_status_pkg::RETRY_CYC,
    parameter int PULSE_CYCLES = supply_status_pkg::PULSE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire supply_status_pkg::reg_req_s i_reg_req,
    output logic [7:0] o_reg_rdata,
    input wire supply_status_pkg::supply_sense_s i_sense,
    output logic o_power_good_n,
    output logic o_int_pulse,
    output logic o_global_int
);
    import supply_status_pkg::*;

    localparam int RW = $clog2(RETRY_CYCLES + 1);
    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam logic [RW-1:0] RETRY_LAST = RW'(RETRY_CYCLES - 1);
    localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYCLES);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic present_s;
    logic in_range_s;
    logic ovp_s;

    // comparators are asynchronous to the clock, two flops each
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= i_sense;
            sync2_q <= sync1_q;
        end
    end
    assign present_s = sync2_q[2];
    assign in_range_s = sync2_q[1];
    assign ovp_s = sync2_q[0];

    // ------------------------------------------------------------------
    // validation sequencer
    // ------------------------------------------------------------------
    valid_state_e state_q, state_d;
    logic [RW-1:0] retry_q, retry_d;
    logic attached_q, attached_d;

    // overvoltage is only looked at through in_range during a check
    always_comb begin
        state_d = state_q;
        retry_d = retry_q;
        attached_d = attached_q;
        case (state_q)
            ST_IDLE: begin
                if (present_s) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                retry_d = '0;
                if (!present_s) begin
                    state_d = ST_IDLE;
                end else if (in_range_s) begin
                    state_d = ST_ATTACHED;
                    attached_d = 1'b1;
                end else begin
                    state_d = ST_FAILED;
                end
            end
            ST_ATTACHED: begin
                // no exit on overvoltage once validated
                if (!present_s) begin
                    state_d = ST_IDLE;
                    attached_d = 1'b0;
                end
            end
            ST_FAILED: begin
                if (!present_s) begin
                    state_d = ST_IDLE;
                end else if (retry_q == RETRY_LAST) begin
                    state_d = ST_CHECK;
                end else begin
                    retry_d = retry_q + RW'(1);
                end
            end
            default: begin
                state_d = ST_IDLE;
                attached_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ST_IDLE;
            retry_q <= '0;
            attached_q <= 1'b0;
        end else begin
            state_q <= state_d;
            retry_q <= retry_d;
            attached_q <= attached_d;
        end
    end

    // ------------------------------------------------------------------
    // status bits, masks and read port
    // ------------------------------------------------------------------
    logic fail_q, fail_d;
    logic pgood_n_q, pgood_n_d;
    logic [2:0] mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic [2:0] ev;
    logic fail_set;
    logic hit_rd;
    logic [7:0] status_word;
    logic hit_wr;
    logic [2:0] wmask;

    assign fail_set = (state_q == ST_CHECK) && present_s && !in_range_s;
    assign hit_rd = i_reg_req.rd && (i_reg_req.addr == STATUS_ADDR);
    // write decode shared by the mask path and its check
    assign hit_wr = i_reg_req.wr && (i_reg_req.addr == STATUS_ADDR);
    assign wmask = i_reg_req.wdata[MASK_ATTACH_BIT:MASK_FAIL_BIT];

    // read-back; reserved bits 4 and 0 tie low
    always_comb begin
        status_word = 8'h00;
        status_word[ATTACHED_BIT] = attached_q;
        status_word[PGOOD_BIT] = pgood_n_q;
        status_word[FAIL_BIT] = fail_q;
        status_word[MASK_ATTACH_BIT] = mask_q[2];
        status_word[MASK_PGOOD_BIT] = mask_q[1];
        status_word[MASK_FAIL_BIT] = mask_q[0];
    end

    // a failure in the read cycle wins over the read clear
    always_comb begin
        fail_d = fail_q;
        if (fail_set) begin
            fail_d = 1'b1;
        end else if (hit_rd) begin
            fail_d = 1'b0;
        end
        pgood_n_d = ~attached_q;
        mask_d = mask_q;
        if (hit_wr) begin
            mask_d = wmask;
        end
        rdata_d = rdata_q;
        if (i_reg_req.rd) begin
            rdata_d = (i_reg_req.addr == STATUS_ADDR) ? status_word : 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fail_q <= 1'b0;
            pgood_n_q <= STATUS_RESET[PGOOD_BIT];
            mask_q <= MASK_RESET;
            rdata_q <= 8'h00;
        end else begin
            fail_q <= fail_d;
            pgood_n_q <= pgood_n_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // event detection and indicator pulse
    // ------------------------------------------------------------------
    logic [PW-1:0] pulse_q, pulse_d;
    logic pulse_on_q, pulse_on_d;
    logic gint_q, gint_d;
    logic trig;

    // events line up with mask bits 3:1
    assign ev[2] = attached_d && !attached_q;
    assign ev[1] = pgood_n_d != pgood_n_q;
    assign ev[0] = fail_set && !fail_q;
    assign trig = |(ev & ~mask_q);

    // retrigger restarts the width so a burst gives one long pulse
    always_comb begin
        pulse_d = pulse_q;
        if (trig) begin
            pulse_d = PULSE_LOAD;
        end else if (pulse_q != '0) begin
            pulse_d = pulse_q - PW'(1);
        end
        pulse_on_d = pulse_d != '0;
        gint_d = |ev;
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_q <= '0;
            pulse_on_q <= 1'b0;
            gint_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            pulse_on_q <= pulse_on_d;
            gint_q <= gint_d;
        end
    end

    // pins come straight from flops so no counter decode can glitch them
    assign o_reg_rdata = rdata_q;
    assign o_power_good_n = pgood_n_q;
    assign o_int_pulse = pulse_on_q;
    assign o_global_int = gint_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    // named steps reused by the properties below
    sequence read_hit;
        hit_rd && !fail_set;
    endsequence
    sequence checked_bad;
        (state_q == ST_CHECK) && present_s && !in_range_s;
    endsequence

    chk_read_clears_fail: assert property (read_hit |=> !fail_q)
        else $error("fail bit not cleared by read");
    chk_attach_holds: assert property (attached_q && present_s |=> attached_q)
        else $error("attach bit dropped while supply present");
    chk_attach_sets: assert property (
        (state_q == ST_CHECK) && present_s && in_range_s |=> attached_q)
        else $error("attach bit not set after good check");
    chk_attach_clears: assert property (!present_s |=> !attached_q)
        else $error("attach bit kept after removal");
    chk_ovp_keeps: assert property (attached_q && present_s && ovp_s |=> attached_q)
        else $error("overvoltage cleared attach bit");
    chk_pgood_level: assert property (hit_rd |=> o_reg_rdata[PGOOD_BIT] == $past(o_power_good_n))
        else $error("bit 6 differs from power good pin");
    chk_fail_sets: assert property (checked_bad |=> fail_q ##0 state_q == ST_FAILED)
        else $error("failed check not flagged");
    chk_retry_period: assert property (
        (state_q == ST_FAILED) && present_s && retry_q == RETRY_LAST |=> state_q == ST_CHECK)
        else $error("retry not started at interval end");
    chk_retry_early: assert property (
        (state_q == ST_FAILED) && retry_q != RETRY_LAST |=> state_q != ST_CHECK)
        else $error("retry started early");
    chk_reserved_zero: assert property (i_reg_req.rd |=> o_reg_rdata[RSVD_BIT] == 1'b0)
        else $error("reserved bit reads nonzero");
    chk_mask_blocks: assert property (
        !o_int_pulse && (ev & ~mask_q) == 3'h0 |=> !o_int_pulse)
        else $error("pulse from masked event");
    chk_global_int: assert property ((|ev) |=> o_global_int)
        else $error("global strobe missing for event");
    chk_pulse_width: assert property ($rose(o_int_pulse) |-> o_int_pulse [*8])
        else $error("indicator pulse too short");
    chk_pulse_start: assert property (trig |=> o_int_pulse ##0 pulse_q == PULSE_LOAD)
        else $error("unmasked event gave no pulse");

    // register port and masks
    chk_bit0_zero: assert property (i_reg_req.rd |=> o_reg_rdata[0] == 1'b0)
        else $error("bit 0 reads nonzero");
    chk_unmapped_zero: assert property (
        i_reg_req.rd && (i_reg_req.addr != STATUS_ADDR) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_mask_write: assert property (hit_wr |=> mask_q == $past(wmask))
        else $error("mask write did not land");
    chk_mask_holds: assert property (!hit_wr |=> $stable(mask_q))
        else $error("mask bits changed without a write");

    // status bits and strobe
    chk_fail_holds: assert property (fail_q && !hit_rd |=> fail_q)
        else $error("fail bit dropped without a read");
    chk_fail_only_check: assert property (!fail_q && !fail_set |=> !fail_q)
        else $error("fail bit set without a failed check");
    chk_pgood_low: assert property (attached_q |=> !o_power_good_n)
        else $error("power good pin high while attached");
    chk_pgood_high: assert property (!attached_q |=> o_power_good_n)
        else $error("power good pin low while detached");
    chk_gint_quiet: assert property (ev == 3'h0 |=> !o_global_int)
        else $error("global strobe without an event");
    chk_detach_event: assert property (attached_q && !present_s |=> ##1 o_global_int)
        else $error("removal gave no power good event");

    // sequencer
    chk_check_once: assert property (state_q == ST_CHECK |=> state_q != ST_CHECK)
        else $error("check state held for more than one cycle");
    chk_retry_bound: assert property (state_q == ST_FAILED |-> retry_q <= RETRY_LAST)
        else $error("retry counter past its last value");

    // indicator pulse
    chk_pulse_ends: assert property (pulse_q == PW'(1) && !trig |=> !o_int_pulse)
        else $error("indicator pulse overran its width");
endmodule
`default_nettype wire

// ---- sim/supply_model.sv ----
// behavioural model of the supply comparators feeding the register block
`timescale 1ns/1ps
`default_nettype none
module supply_model (
    input wire logic i_ref_clk,
    input wire logic i_present,
    input wire logic i_in_range,
    input wire logic i_overvoltage,
    output var supply_status_pkg::supply_sense_s o_sense
);
    import supply_status_pkg::*;
    // comparator outputs change just after an edge, like a slow analog front end;
    // an overvoltage takes the supply out of range, as a real window comparator would
    always @(posedge i_ref_clk) begin
        o_sense <= '{present: i_present, in_range: i_in_range & i_present & ~i_overvoltage,
                     overvoltage: i_overvoltage & i_present};
    end
endmodule
`default_nettype wire

// ---- sim/test_supply_status_interrupt_reg.sv ----
// self-checking bench for the supply status and event mask register
`timescale 1ns/1ps
`default_nettype none
module test_supply_status_interrupt_reg;
    import supply_status_pkg::*;
    localparam int RETRY = 50;
    localparam int PULSE = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_s req = '0;
    supply_sense_s sense;
    logic sup_on = 1'b0, sup_ok = 1'b0, sup_ovp = 1'b0;
    logic [7:0] rdata;
    logic pg_n, int_pulse, gint;
    int err_total = 0, cmp_count = 0, rises = 0, hi_cnt = 0, last_width = 0, n = 0, r0 = 0;
    int ticks = 0, t0 = 0;
    // ----------------------------------------------------------------
    // clock, model and design
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end
    supply_model u_sup (.i_ref_clk(clk), .i_present(sup_on), .i_in_range(sup_ok),
        .i_overvoltage(sup_ovp), .o_sense(sense));
    supply_status_interrupt_reg #(.RETRY_CYCLES(RETRY), .PULSE_CYCLES(PULSE)) u_dut (
        .i_ref_clk(clk), .i_arst_n(arst_n), .i_reg_req(req), .o_reg_rdata(rdata),
        .i_sense(sense), .o_power_good_n(pg_n), .o_int_pulse(int_pulse), .o_global_int(gint));
    // monitor: cycle count, rising edges and width of the indicator pulse
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (int_pulse === 1'b1) begin
            if (hi_cnt == 0) rises <= rises + 1;
            hi_cnt <= hi_cnt + 1;
        end else if (hi_cnt != 0) begin
            last_width <= hi_cnt;
            hi_cnt <= 0;
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // read strobe one cycle, data sampled once the following edge lands
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // bounded wait for the global interrupt strobe; k returns cycles waited
    task automatic wait_gint(input int bound, output int k);
        for (k = 1; k <= bound; k++) begin
            cyc(1);
            if (gint === 1'b1) return;
        end
        err_total++;
        tally_and_finish();
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        reg_rd(8'h07, STATUS_RESET);
        reg_rd(8'h06, 8'h00);
        reg_wr(8'h07, 8'hff);
        reg_rd(8'h07, 8'h4e);
        // masked attach: status and strobe update, pin stays quiet
        r0 = rises;
        @(posedge clk);
        sup_on <= 1'b1;
        sup_ok <= 1'b1;
        wait_gint(20, n);
        cyc(PULSE + 6);
        check(rises, r0);
        check(pg_n, 1'b0);
        reg_rd(8'h07, 8'h8e);
        reg_rd(8'h07, 8'h8e);
        @(posedge clk);
        sup_ovp <= 1'b1;
        cyc(8);
        reg_rd(8'h07, 8'h8e);
        @(posedge clk);
        sup_on <= 1'b0;
        sup_ovp <= 1'b0;
        cyc(8);
        reg_rd(8'h07, 8'h4e);
        // unmasked validation failure with periodic retry; the read clear rearms the event
        reg_wr(8'h07, 8'h00);
        r0 = rises;
        @(posedge clk);
        sup_ok <= 1'b0;
        sup_on <= 1'b1;
        wait_gint(20, n);
        t0 = ticks;
        reg_rd(8'h07, 8'h60);
        reg_rd(8'h07, 8'h40);
        wait_gint(RETRY + 20, n);
        check((ticks - t0) >= RETRY && (ticks - t0) <= RETRY + 2, 1'b1);
        reg_rd(8'h07, 8'h60);
        reg_rd(8'h07, 8'h40);
        cyc(PULSE);
        check(rises - r0, 2);
        check(last_width, PULSE);
        // failure event masked: strobe still comes, pin stays quiet
        reg_wr(8'h07, 8'h02);
        r0 = rises;
        wait_gint(RETRY + 20, n);
        cyc(PULSE + 4);
        check(rises, r0);
        reg_rd(8'h07, 8'h62);
        // mid-run reset: outputs fall back and the masks return to zero
        @(posedge clk);
        arst_n <= 1'b0;
        cyc(3);
        check(pg_n, 1'b1);
        check(int_pulse, 1'b0);
        check(rdata, 8'h00);
        @(posedge clk);
        arst_n <= 1'b1;
        reg_rd(8'h07, STATUS_RESET);
        tally_and_finish();
    end
endmodule
`default_nettype wire
